// ==== rtl/drmc_ctrl.sv ====
// Purpose: request handling and bus/transfer mode control, four channels
// Assumes: one unit moved per XFER_DONE pulse; external bus grant given
// Notes:   bus occupancy is reported, not arbitrated, beyond lowest-index
// block outline
// - four channels share one engine; only one runs at a time
// - each channel has a mode word and a 24-bit count word
// - a channel is ready when enabled and its source asks
// - auto source: always asking while enabled
// - external source: pin low, or a pending falling edge
// - usb source: the usb request level for that channel
// - the engine picks the lowest ready index from idle
// - one unit runs per completion pulse on the bus side
// - after release the engine spends one gap cycle idle
// - the gap lets another master or channel win the bus
//
// bus and transfer modes
// - cycle steal: the bus is given back after every unit, in block mode after each block
// - burst: kept until the count ends or enable drops
// - burst is only honoured for the auto source
// - block: size field plus one units per request
// - block is only honoured for the external source
// - usb source is forced to cycle steal, normal mode
// - illegal mode mixes fall back to cycle steal, normal
//
// counting
// - normal mode: the full 24 bits count units down
// - block mode: the low 16 bits count whole blocks
// - block mode: the size field is never altered
// - a zero count stays zero and the run never ends
// - the unit that takes the count to zero is the last
//
// strobes
// - ack pulses once when an external start is taken with ack enabled
// - in block mode that is once per block, by nature
// - end pulses on the last unit, or each block end
// - both strobes are registered to stay glitch free
//
// hazards a user must know
// - writing a running channel's count wins over update
// - clearing enable lets the current unit complete
// - an nmi event aborts a block, not a normal run
// - a repeat event clears enable of the addressed channel
//
// The register addresses and the APB register port were decided locally.
module drmc_ctrl
    import drmc_pkg::*;
(
    // clock and reset
    input  wire logic            CLK,
    input  wire logic            RST_N,
    // apb slave
    input  wire logic            PSEL,
    input  wire logic            PENABLE,
    input  wire logic            PWRITE,
    input  wire logic [11:0]     PADDR,
    input  wire logic [31:0]     PWDATA,
    output logic      [31:0]     PRDATA,
    output logic                 PREADY,
    output logic                 PSLVERR,
    // external requester, active low pins
    input  wire logic [NCH-1:0]  EXT_REQ_N,
    output logic      [NCH-1:0]  REQ_ACK_N,
    output logic      [NCH-1:0]  XFER_END_N,
    // on-chip usb requests and endpoint select
    input  wire logic [NCH-1:0]  USB_REQ,
    output logic      [NCH-1:0]  USB_EP2_DIR,
    // bus cycle side
    output logic      [NCH-1:0]  XFER_GO,
    input  wire logic            XFER_DONE,
    output logic                 BUS_HOLD
);
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_GAP} drmc_state_t;

    drmc_state_t                  state;
    drmc_state_t                  next_state;
    logic [MODE_W-1:0]            mode  [NCH];
    logic [23:0]                  count [NCH];
    logic [7:0]                   blk_left;
    logic [1:0]                   cur;
    logic [NCH-1:0]               pend;
    logic [NCH-1:0]               sync1;
    logic [NCH-1:0]               sync2;
    logic [NCH-1:0]               sync3;
    logic [NCH-1:0]               ack_q;
    logic [NCH-1:0]               end_q;

    // apb decode
    // the slave never stalls: pready is tied high, so an
    // access completes in its first enable cycle
    // channel n sits at a 16-byte stride from zero
    // four words per channel: mode, count, status, event
    // anything above channel three is unmapped
    // unmapped accesses raise pslverr and change nothing
    // the event word is write only and holds no state:
    // each set bit is a one-cycle strobe into the engine
    wire        acc    = PSEL && PENABLE;
    wire        wr     = acc && PWRITE;
    wire [1:0]  sel_ch = PADDR[CH_STRIDE_SH+1:CH_STRIDE_SH];
    wire [11:0] sub    = {8'h00, PADDR[3:0]};
    wire        hit_md = sub == OFS_MODE;
    wire        hit_ct = sub == OFS_COUNT;
    wire        hit_st = sub == OFS_STATUS;
    wire        hit_ev = sub == OFS_EVENT;
    wire        mapped = (PADDR[11:6] == 6'h00) && (hit_md || hit_ct
                         || hit_st || hit_ev);
    wire        ev_wr  = wr && mapped && hit_ev;
    wire        rpt_ev = ev_wr && PWDATA[EV_RPT];
    wire        nmi_ev = ev_wr && PWDATA[EV_NMI];

    assign PREADY  = 1'b1;
    assign PSLVERR = acc && !mapped;

    // current channel view
    // cur is only loaded from idle, so while running these
    // wires describe the channel that owns the bus
    // block and burst are masked by source here, which is
    // how illegal mode mixes are made harmless
    // cnt_lo marks the final counted step: one unit in
    // normal mode, one block in block mode
    // last is the completion that ends the whole run
    wire [MODE_W-1:0] cm   = mode[cur];
    wire [1:0]  csrc   = cm[F_SRC+1:F_SRC];
    wire        cblock = cm[F_BLOCK] && (csrc == SRC_EXT);
    wire        cburst = cm[F_BURST] && (csrc == SRC_AUTO);
    wire [23:0] ccnt   = count[cur];
    wire        cnt_lo = cblock ? (ccnt[15:0] == 16'h0001)
                                : (ccnt == 24'h000001);
    wire        blk_end = cblock && (blk_left == 8'h00);
    wire        last    = XFER_DONE && cnt_lo && (!cblock || blk_end);

    // per-channel request qualification and selection
    logic [NCH-1:0] ready;
    genvar g;
    generate
        for (g = 0; g < NCH; g++)
        begin : gch
            wire [1:0] s = mode[g][F_SRC+1:F_SRC];
            wire lvl = mode[g][F_SENSE] ? pend[g] : !sync2[g];
            assign ready[g] = mode[g][F_EN] && (
                (s == SRC_AUTO) ||
                (s == SRC_EXT && lvl) ||
                (s == SRC_USB && USB_REQ[g]));
            assign USB_EP2_DIR[g] = mode[g][F_EP];
        end
    endgenerate

    wire [1:0] pick = ready[0] ? 2'd0 : ready[1] ? 2'd1 :
                      ready[2] ? 2'd2 : 2'd3;
    // stay on this channel in burst or inside a block, else release
    wire keep = !last && ((cburst && cm[F_EN]) || (cblock && !blk_end));

    // engine sequence
    // idle: wait for any ready channel, then take the bus
    // run: one channel owns the bus until a release cause
    // gap: one cycle with the bus free before idle again
    // release causes, in order of weight:
    // - nmi abort of a block in progress
    // - repeat overflow event
    // - a completion that does not keep the bus
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE: if (|ready) next_state = ST_RUN;
            ST_RUN:
                if (nmi_ev && cblock) next_state = ST_GAP;
                else if (rpt_ev) next_state = ST_GAP;
                else if (XFER_DONE && !keep) next_state = ST_GAP;
            ST_GAP: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    // state and current channel
    always_ff @(posedge CLK)
    begin
        if (!RST_N) state <= ST_IDLE;
        else state <= next_state;
        if (!RST_N) cur <= 2'd0;
        else if (state == ST_IDLE && |ready) cur <= pick;
    end

    // block residue: loaded from size field, counts units in block
    always_ff @(posedge CLK)
    begin
        if (!RST_N) blk_left <= 8'h00;
        else if (state == ST_IDLE && |ready) blk_left <= count[pick][23:16];
        else if (state == ST_RUN && XFER_DONE && !blk_end)
            blk_left <= blk_left - 8'h01;
    end

    // request pin synchroniser and falling-edge capture
    // the pins are asynchronous: two flops before use
    // the third flop only remembers the last synced level
    // so a fall is seen exactly once per transition
    // reset to the idle high level to avoid a false fall
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            sync1 <= '1;
            sync2 <= '1;
            sync3 <= '1;
        end
        else
        begin
            sync1 <= EXT_REQ_N;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    wire [NCH-1:0] fall = sync3 & ~sync2;
    wire start = state == ST_IDLE && |ready;
    logic [NCH-1:0] take;
    always_comb
    begin
        take = '0;
        if (start) take[pick] = 1'b1;
    end

    // pending edge flags: a new fall wins over consumption
    always_ff @(posedge CLK)
    begin
        if (!RST_N) pend <= '0;
        else pend <= fall | (pend & ~take);
    end

    // mode and count registers, software write wins over update
    // done is only true for the running channel, so the
    // current view wires may be used inside the loop
    // the enable bit is cleared by the last completion
    // or by a repeat event aimed at this channel
    // block mode counts a block when its last unit ends
    // normal mode counts every unit on all 24 bits
    // a count of zero holds, giving an endless run
    generate
        for (g = 0; g < NCH; g++)
        begin : greg
            wire me   = state != ST_IDLE && cur == g;
            wire wm   = wr && mapped && hit_md && sel_ch == g;
            wire wc   = wr && mapped && hit_ct && sel_ch == g;
            wire done = me && state == ST_RUN && XFER_DONE;
            wire kill = (rpt_ev && sel_ch == g) ||
                        (done && cnt_lo && (!cblock || blk_end));
            wire blk_done = done && cblock && blk_end;
            always_ff @(posedge CLK)
            begin
                if (!RST_N) mode[g] <= MODE_RST;
                else if (wm) mode[g] <= PWDATA[MODE_W-1:0];
                else if (kill) mode[g][F_EN] <= 1'b0;
            end
            always_ff @(posedge CLK)
            begin
                if (!RST_N) count[g] <= CNT_RST;
                else if (wc) count[g] <= PWDATA[23:0];
                else if (blk_done && count[g][15:0] != 16'h0000)
                    count[g][15:0] <= count[g][15:0] - 16'h0001;
                else if (done && !cblock && count[g] != 24'h000000)
                    count[g] <= count[g] - 24'h000001;
            end
        end
    endgenerate

    // acknowledge and end strobes, registered, active low
    // ack goes out in the first run cycle of an external
    // start when acknowledge is enabled; the requester
    // uses it to drop its request line
    // end goes out in the cycle after the closing unit
    // both are single-cycle pulses and default high
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            ack_q <= '0;
            end_q <= '0;
        end
        else
        begin
            ack_q <= '0;
            end_q <= '0;
            if (start && mode[pick][F_AKEN] &&
                mode[pick][F_SRC+1:F_SRC] == SRC_EXT)
                ack_q[pick] <= 1'b1;
            if (state == ST_RUN && XFER_DONE &&
                (cblock ? blk_end : cnt_lo))
                end_q[cur] <= 1'b1;
        end
    end
    assign REQ_ACK_N  = ~ack_q;
    assign XFER_END_N = ~end_q;

    // unit go strobe; enable clear lets the running unit finish
    logic [NCH-1:0] go;
    always_comb
    begin
        go = '0;
        if (state == ST_RUN) go[cur] = 1'b1;
    end
    assign XFER_GO  = go;
    assign BUS_HOLD = state == ST_RUN;

    // read mux
    // read data is captured in the setup cycle and stands
    // through the access cycle, so the zero-wait answer
    // is always settled when the master samples it
    // unmapped reads return zero
    wire [31:0] st_word = {24'h000000, 4'h0, (state == ST_RUN), cur,
                           pend[sel_ch]};
    always_ff @(posedge CLK)
    begin
        if (!RST_N) PRDATA <= RD_NONE;
        else if (PSEL && !PENABLE && !PWRITE)
            PRDATA <= !mapped ? RD_NONE :
                      hit_md ? {24'h000000, mode[sel_ch]} :
                      hit_ct ? {8'h00, count[sel_ch]} :
                      hit_st ? st_word : RD_NONE;
    end
endmodule

// ==== rtl/drmc_pkg.sv ====
// Purpose: constants for the dma request and mode control block
// Assumes: 32-bit apb, word-aligned registers
// Notes:   register offsets are byte addresses
package drmc_pkg;
    localparam int NCH = 4;
    // register map, per channel stride 0x10
    localparam logic [11:0] OFS_MODE   = 12'h000; // channel_mode_control_register
    localparam logic [11:0] OFS_COUNT  = 12'h004; // transfer_count_register
    localparam logic [11:0] OFS_STATUS = 12'h008; // status, read only
    localparam logic [11:0] OFS_EVENT  = 12'h00c; // event strobes, write only
    localparam int CH_STRIDE_SH = 4;
    // mode register fields
    localparam int F_EN    = 0;  // transfer_enable_bit
    localparam int F_SRC   = 1;  // 2 bits: request source
    localparam int F_BURST = 3;  // bus mode: 1 burst, 0 cycle steal
    localparam int F_BLOCK = 4;  // transfer mode: 1 block
    localparam int F_SENSE = 5;  // request_sense_select
    localparam int F_AKEN  = 6;  // request_ack_enable
    localparam int F_EP    = 7;  // usb endpoint: 0 ep1 (from), 1 ep2 (to)
    localparam int MODE_W  = 8;
    localparam logic [MODE_W-1:0] MODE_RST = 8'h00;
    // request sources
    localparam logic [1:0] SRC_AUTO = 2'h0;
    localparam logic [1:0] SRC_EXT  = 2'h1;
    localparam logic [1:0] SRC_USB  = 2'h2;
    // event register bits
    localparam int EV_RPT = 0;   // repeat-area overflow
    localparam int EV_NMI = 1;   // non-maskable interrupt abort
    localparam logic [23:0] CNT_RST = 24'h000000;
    localparam logic [31:0] RD_NONE = 32'h00000000;
endpackage

// ==== bench/drmc_sva.sv ====
// Purpose: port checks for the request and mode control block
// Assumes: one clock, synchronous active-low reset
// Notes:   sees only the top-level ports
module drmc_sva
    import drmc_pkg::*;
(
    // clock, reset and apb
    input wire logic           CLK,
    input wire logic           RST_N,
    input wire logic           PSEL,
    input wire logic           PENABLE,
    input wire logic           PWRITE,
    // channel side
    input wire logic [NCH-1:0] REQ_ACK_N,
    input wire logic [NCH-1:0] XFER_END_N,
    input wire logic [NCH-1:0] USB_EP2_DIR,
    input wire logic [NCH-1:0] XFER_GO,
    input wire logic           XFER_DONE,
    input wire logic           BUS_HOLD
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    wire logic apb_wr;
    // a register write lands in this cycle
    assign apb_wr = PSEL && PENABLE && PWRITE;
    chk_ack_pulse: assert property (REQ_ACK_N != 4'hf |=> REQ_ACK_N == 4'hf)
        else $error("ack strobe longer than one cycle");
    chk_ack_go: assert property ((~REQ_ACK_N & ~XFER_GO) == 4'h0)
        else $error("ack without its channel running");
    chk_ack_hold: assert property (REQ_ACK_N != 4'hf |-> BUS_HOLD)
        else $error("ack while bus not held");
    chk_end_pulse: assert property (XFER_END_N != 4'hf |=> XFER_END_N == 4'hf)
        else $error("end strobe longer than one cycle");
    chk_go_hold: assert property (XFER_GO != 4'h0 |-> BUS_HOLD)
        else $error("unit running without the bus");
    chk_go_single: assert property ($onehot0(XFER_GO))
        else $error("two channels running at once");
    chk_gap_cycle: assert property ($fell(BUS_HOLD) |=> !BUS_HOLD)
        else $error("no release cycle after bus release");
    chk_hold_cause: assert property ($rose(BUS_HOLD) |-> XFER_GO != 4'h0)
        else $error("bus taken with no channel running");
    chk_go_steady: assert property (XFER_GO != 4'h0 && !XFER_DONE
        && !$past(XFER_DONE) && !apb_wr |=> XFER_GO == $past(XFER_GO))
        else $error("running channel changed mid unit");
    chk_dir_steady: assert property (!apb_wr |=> $stable(USB_EP2_DIR))
        else $error("endpoint select changed without a write");
    // main scenarios
    cover property (REQ_ACK_N != 4'hf);
    cover property (XFER_END_N != 4'hf);
    cover property ($fell(BUS_HOLD));
endmodule

// ==== bench/drmc_peer.sv ====
// Purpose: external requester and unit-completion model
// Assumes: requester drops its request once acknowledged
// Notes:   unit latency is lat plus one cycles, at least one
module drmc_peer
    import drmc_pkg::*;
(
    // clock and reset
    input  wire logic           clk,
    input  wire logic           rst_n,
    // bench controls
    input  wire logic [NCH-1:0] want,
    input  wire logic [3:0]     lat,
    // controller side
    input  wire logic [NCH-1:0] ack_n,
    input  wire logic [NCH-1:0] go,
    output logic      [NCH-1:0] req_n,
    output logic                done
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [NCH-1:0] held = 4'h0;
    logic [3:0]     wait_cnt = 4'h0;
    logic           done_r = 1'b0;
    // request low while wanted and not yet acknowledged
    assign req_n = ~(want & ~held);
    assign done  = done_r;
    // an ack is remembered until the bench withdraws the request
    always @(posedge clk)
        held <= (held | ~ack_n) & want;
    // one completion pulse per unit after lat plus one running cycles
    always @(posedge clk)
    begin
        done_r   <= rst_n && go != 4'h0 && !done_r && wait_cnt >= lat;
        wait_cnt <= (go == 4'h0 || done_r) ? 4'h0 : wait_cnt + 4'h1;
    end
endmodule

// ==== bench/tb_top.sv ====
// Purpose: self-checking bench for the request and mode control block
// Assumes: apb master tasks, peer model on requests and completions
// Notes:   expectations come from the mode and count settings
module tb_top;
    import drmc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] EN = 32'h1, BU = 32'h8, BL = 32'h10;
    localparam logic [31:0] EXT = 32'h2, USB = 32'h4, SE = 32'h20;
    localparam logic [31:0] AK = 32'h40, EP = 32'h80;
    logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, pready, pslverr, err, done, hold;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [3:0]  req_n, ack_n, end_n, ep2, go;
    logic [3:0]  usb = 4'h0, want = 4'h0, lat = 4'h1;
    int          miscompares = 0, total_checks = 0, b[4];
    int          nd = 0, na = 0, ne = 0, nh = 0;
    drmc_ctrl dut (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .EXT_REQ_N(req_n),
        .REQ_ACK_N(ack_n), .XFER_END_N(end_n), .USB_REQ(usb),
        .USB_EP2_DIR(ep2), .XFER_GO(go), .XFER_DONE(done), .BUS_HOLD(hold));
    drmc_peer peer (.clk(clk), .rst_n(rst_n), .want(want), .lat(lat),
        .ack_n(ack_n), .go(go), .req_n(req_n), .done(done));
    // clock
    initial
    begin
        forever #10 clk = ~clk;
    end
    // event counters
    always @(posedge clk)
    begin
        nd <= nd + int'(done);
        na <= na + $countones(~ack_n);
        ne <= ne + $countones(~end_n);
        nh <= nh + int'($rose(hold));
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input int ch, input logic [11:0] o,
        input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, pwdata} <= {2'b10, w, d};
        paddr <= 12'(ch << CH_STRIDE_SH) | o;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic setup(input int ch, input logic [31:0] m, c);
        b = '{nd, na, ne, nh};
        apb(1'b1, ch, OFS_COUNT, c);
        apb(1'b1, ch, OFS_MODE, m);
    endtask
    task automatic finish(input int ch, u, a, e, h, input logic [31:0] c, m);
        for (int i = 0; i < 400 && (nd - b[0] < u || hold !== 1'b0); i++)
            @(posedge clk);
        repeat (4) @(posedge clk);
        if (u >= 0) check(nd - b[0], u);
        check(na - b[1], a);
        check(ne - b[2], e);
        if (h >= 0) check(nh - b[3], h);
        apb(1'b0, ch, OFS_COUNT, 0);
        check(q, c);
        apb(1'b0, ch, OFS_MODE, 0);
        check(q, m);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        #400us;
        miscompares++;
        final_report();
    end
    // test sequence
    initial
    begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, 0, OFS_MODE, 0);
        check(q, 32'(MODE_RST));
        apb(1'b0, 4, OFS_MODE, 0);
        check({q[30:0], err}, 32'h1);
        setup(0, EN, 3);
        finish(0, 3, 0, 1, 3, 0, 0);
        lat <= 4'h3;
        setup(1, EN | BU, 4);
        finish(1, 4, 0, 1, 1, 0, BU);
        lat <= 4'h1;
        setup(2, EN | BL, 2);
        finish(2, 2, 0, 1, 2, 0, BL);
        want <= 4'h2;
        setup(1, EXT | AK, 1);
        repeat (20) @(posedge clk);
        check(go, 0);
        setup(1, EN | EXT | AK, 1);
        finish(1, 1, 1, 1, 1, 0, EXT | AK);
        want <= 4'h0;
        repeat (2) @(posedge clk);
        want <= 4'h2;
        setup(1, EN | EXT | BU, 2);
        finish(1, 2, 0, 1, 2, 0, EXT | BU);
        want <= 4'h0;
        setup(2, EN | EXT | BL | SE | AK, 24'h010003);
        want <= 4'h4;
        finish(2, 2, 1, 1, 1, 24'h010002, EN | EXT | BL | SE | AK);
        want <= 4'h0;
        repeat (2) @(posedge clk);
        lat <= 4'h8;
        b = '{nd, na, ne, nh};
        want <= 4'h4;
        for (int i = 0; i < 50 && go !== 4'h4; i++) @(posedge clk);
        apb(1'b1, 0, OFS_EVENT, 32'h1 << EV_NMI);
        repeat (30) @(posedge clk);
        check(32'(nd - b[0] < 2), 1);
        check(32'(hold), 0);
        want <= 4'h0;
        lat <= 4'h1;
        apb(1'b1, 2, OFS_MODE, 0);
        usb <= 4'h8;
        setup(3, EN | USB | EP, 1);
        @(negedge clk);
        check(ep2, 4'h8);
        finish(3, 1, 0, 1, 1, 0, USB | EP);
        usb <= 4'h0;
        setup(0, EN, 0);
        repeat (30) @(posedge clk);
        apb(1'b1, 0, OFS_EVENT, 32'h1 << EV_RPT);
        finish(0, -1, 0, 0, -1, 0, 0);
        b[0] = nd;
        repeat (20) @(posedge clk);
        check(nd - b[0], 0);
        final_report();
    end
endmodule
bind drmc_ctrl drmc_sva chk (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .REQ_ACK_N(REQ_ACK_N),
    .XFER_END_N(XFER_END_N), .USB_EP2_DIR(USB_EP2_DIR),
    .XFER_GO(XFER_GO), .XFER_DONE(XFER_DONE), .BUS_HOLD(BUS_HOLD));
